// ### rtl/seebr_core.sv
// two-wire eeprom slave control: recovery, power-on clear, write commit
// Summary of operation
// R01: low supply at stop cancels the write
// R02: start then stop returns logic idle
// R03: master reset alone changes nothing here
// R04: zero bit or ack holds data low
// R05: master recovers: start, nine clocks, start, stop
// R06: master high reading aborts output phase
// R07: master sends start right after dummies
// R08: master runs recovery at system start
// R09: master checks acknowledges except in dummy write, abort and stuck tests
// R10: power-on clear ignores bus until done
// R11: bad ramp: master runs recovery first
// R12: write only on stop right after ack
// R13: start aborts command being shifted in
// R14: after cancel master uses random read
// R15: master frees low data before start
// R16: write cycle ignores bus, no ack
// R17: low supply flag sampled at stop
`timescale 1ns/10ps
module seebr_core
	import seebr_pkg::*;
#(
	parameter int unsigned INIT_CNT  = INIT_CYCLES,
	parameter int unsigned WRITE_CNT = WRITE_CYCLES
)
(
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	input  wire logic        low_vdd_i,
	input  wire logic [7:0]  rd_data_i,
	output logic             sda_o,
	output logic             sda_oe_n_o,
	output logic             busy_o,
	output logic             ready_o,
	output logic             wr_start_o,
	output logic             wr_cancel_o,
	output logic [7:0]       wr_count_o
);
	import seebr_pkg::*;

	seebr_bus_ev_t ev;
	seebr_phase_t  phase_reg;
	logic [2:0]    bit_reg;
	logic [7:0]    shift_reg;
	logic [1:0]    byte_reg;
	logic [7:0]    data_cnt_reg;
	logic          ack_phase_reg;
	logic          ack_done_reg;
	logic          drive_low_reg;
	logic          out_phase_reg;
	logic          rd_reg;
	logic [CNT_W-1:0] timer_reg;
	logic          init_reg;
	logic          write_reg;
	logic          low_s1_reg;
	logic          low_s2_reg;
	logic          wr_start_reg;
	logic          wr_cancel_reg;
	logic [7:0]    wr_count_reg;

	seebr_sync u_sync
	(
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.ev_o      (ev)
	);

	// bus is ignored during init and write cycle
	wire bus_live   = ~init_reg & ~write_reg; // R10 R16
	wire commit_ok  = ack_done_reg & ~rd_reg & (data_cnt_reg != 8'h00); // R12
	wire commit     = bus_live & ev.stop & commit_ok;
	wire addr_match = (shift_reg[7:1] == DEV_ADDR_DEF);
	wire byte_end   = ev.rise & (bit_reg == BIT_LAST) & ~ack_phase_reg;
	wire [7:0] rx_byte = {shift_reg[6:0], ev.sda};

	function automatic logic [CNT_W-1:0] cnt_load(input int unsigned n);
		cnt_load = CNT_W'(n - 1);
	endfunction

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			low_s1_reg <= 1'b0;
			low_s2_reg <= 1'b0;
		end
		else
		begin
			low_s1_reg <= low_vdd_i;
			low_s2_reg <= low_s1_reg; // R17
		end
	end

	// power-on clear and write cycle timer
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			init_reg  <= 1'b1;
			write_reg <= 1'b0;
			timer_reg <= cnt_load(INIT_CNT);
		end
		else if (init_reg | write_reg)
		begin
			if (timer_reg == '0)
			begin
				init_reg  <= 1'b0; // R10
				write_reg <= 1'b0; // R16
			end
			else
				timer_reg <= timer_reg - 1'b1;
		end
		else if (commit & ~low_s2_reg)
		begin
			write_reg <= 1'b1;
			timer_reg <= cnt_load(WRITE_CNT);
		end
	end

	// serial protocol engine; only bus events change state, so a lone
	// master reset leaves it untouched
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i || !bus_live || ev.stop || ev.start) // R02 R03 R13
		begin
			phase_reg       <= SEEBR_ADDR;
			bit_reg         <= '0;
			byte_reg        <= '0;
			data_cnt_reg    <= '0;
			ack_phase_reg   <= 1'b0;
			ack_done_reg    <= 1'b0;
			drive_low_reg   <= 1'b0;
			out_phase_reg   <= 1'b0;
			rd_reg          <= 1'b0;
			shift_reg       <= '0;
		end
		else if (phase_reg != SEEBR_IGNORE)
		begin
			if (ev.rise & ~ack_phase_reg)
			begin
				shift_reg <= rx_byte;
				bit_reg   <= bit_reg + 1'b1;
			end
			if (byte_end)
				ack_phase_reg <= 1'b1;
			if (ev.rise & ack_phase_reg)
			begin
				ack_phase_reg <= 1'b0;
				if (out_phase_reg & ev.sda)
				begin
					phase_reg     <= SEEBR_IGNORE; // R06
					out_phase_reg <= 1'b0;
				end
				else
					ack_done_reg <= ~out_phase_reg;
			end
			if (ev.fall)
			begin
				// the rise of a stop leaves the ack standing
				if (bit_reg != '0)
					ack_done_reg <= 1'b0; // R12
				if (ack_phase_reg & ~out_phase_reg)
				begin
					if (phase_reg == SEEBR_ADDR)
					begin
						if (addr_match)
						begin
							drive_low_reg <= 1'b0;
							rd_reg        <= shift_reg[0];
							phase_reg     <= shift_reg[0] ? SEEBR_READ : SEEBR_WRITE;
						end
						else
							phase_reg <= SEEBR_IGNORE;
					end
					if (phase_reg != SEEBR_ADDR || addr_match)
						drive_low_reg <= 1'b1; // R04
					if (phase_reg == SEEBR_WRITE)
					begin
						if (byte_reg == 2'h2)
							data_cnt_reg <= data_cnt_reg + 1'b1;
						else
							byte_reg <= byte_reg + 1'b1;
					end
				end
				else if ((phase_reg == SEEBR_READ) & ~ack_phase_reg)
				begin
					out_phase_reg <= 1'b1;
					drive_low_reg <= ~rd_data_i[BIT_LAST - bit_reg]; // R04
				end
				else
					drive_low_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			wr_start_reg  <= 1'b0;
			wr_cancel_reg <= 1'b0;
			wr_count_reg  <= '0;
		end
		else
		begin
			wr_start_reg  <= commit & ~low_s2_reg; // R12
			wr_cancel_reg <= commit & low_s2_reg; // R01
			if (commit)
				wr_count_reg <= data_cnt_reg;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			sda_o      <= 1'b1;
			sda_oe_n_o <= 1'b1;
			busy_o     <= 1'b1;
			ready_o    <= 1'b0;
		end
		else
		begin
			sda_o      <= 1'b0;
			sda_oe_n_o <= ~(drive_low_reg & bus_live); // R04 R16
			busy_o     <= write_reg;
			ready_o    <= bus_live;
		end
	end

	assign wr_start_o  = wr_start_reg;
	assign wr_cancel_o = wr_cancel_reg;
	assign wr_count_o  = wr_count_reg;

	a_init_blocks: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R10
		init_reg |-> ##1 sda_oe_n_o)
		else $error("device drove sda during init");
	a_write_silent: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R16
		write_reg |-> ##1 sda_oe_n_o)
		else $error("device drove sda during write cycle");
	a_low_cancel: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R01
		(commit && low_s2_reg) |=> (wr_cancel_o && !wr_start_o))
		else $error("write not cancelled on low supply");
	a_commit_start: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R12
		wr_start_o |-> $past(ack_done_reg) && $past(data_cnt_reg) != 8'h00)
		else $error("write started without acked data");
	a_stop_idle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R02
		(ev.stop && bus_live) |=> (phase_reg == SEEBR_ADDR && !drive_low_reg))
		else $error("stop did not return to idle");
	a_start_abort: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R13
		ev.start |=> (bit_reg == 3'h0 && byte_reg == 2'h0))
		else $error("start did not abort command");
	a_nack_release: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
		(ev.rise && ack_phase_reg && out_phase_reg && ev.sda && bus_live && !ev.stop && !ev.start)
		|=> phase_reg == SEEBR_IGNORE ##1 sda_oe_n_o)
		else $error("output not abandoned on master high");
	a_hold_state: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R03
		(!ev.start && !ev.stop && !ev.rise && !ev.fall && bus_live && $past(bus_live)) |=> $stable(phase_reg))
		else $error("state moved without bus event");
endmodule

// ### rtl/seebr_pkg.sv
// package: constants and carrier types for the eeprom bus-recovery controller
package seebr_pkg;
	localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
	localparam int unsigned INIT_TIME_US  = 100;
	localparam int unsigned INIT_CYCLES   = (INIT_TIME_US * (CLK_FREQ_HZ / 1_000_000));
	localparam int unsigned WRITE_TIME_US = 5000;
	localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000));
	localparam int unsigned CNT_W         = 20;
	localparam logic [2:0]  BIT_LAST      = 3'h7;
	localparam logic [6:0]  DEV_ADDR_DEF  = 7'h50;

	typedef enum logic [1:0] {
		SEEBR_ADDR,
		SEEBR_WRITE,
		SEEBR_READ,
		SEEBR_IGNORE
	} seebr_phase_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} seebr_bus_ev_t;

	typedef struct packed {
		logic       req;
		logic [7:0] count;
	} seebr_wr_t;
endpackage

// ### rtl/seebr_sync.sv
// two-stage synchroniser and bus event detector for scl/sda
`timescale 1ns/10ps
module seebr_sync
	import seebr_pkg::*;
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    nrst_i,
	input  wire logic                    scl_i,
	input  wire logic                    sda_i,
	output seebr_pkg::seebr_bus_ev_t     ev_o
);
	logic [1:0] scl_meta_reg;
	logic [1:0] sda_meta_reg;
	logic       scl_reg;
	logic       sda_reg;

	wire scl_s = scl_meta_reg[1];
	wire sda_s = sda_meta_reg[1];

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			scl_meta_reg <= 2'h3;
			sda_meta_reg <= 2'h3;
			scl_reg      <= 1'b1;
			sda_reg      <= 1'b1;
		end
		else
		begin
			scl_meta_reg <= {scl_meta_reg[0], scl_i};
			sda_meta_reg <= {sda_meta_reg[0], sda_i};
			scl_reg      <= scl_s;
			sda_reg      <= sda_s;
		end
	end

	assign ev_o.start = scl_s & scl_reg & sda_reg & ~sda_s;
	assign ev_o.stop  = scl_s & scl_reg & ~sda_reg & sda_s;
	assign ev_o.rise  = scl_s & ~scl_reg;
	assign ev_o.fall  = ~scl_s & scl_reg;
	assign ev_o.sda   = sda_s;
endmodule

// ### test/seebr_master_model.sv
// two-wire bus master model: scl and open-drain data pull
`timescale 1ns/10ps
module seebr_master_model
(
	input  wire logic ref_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_n_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// data moves mid-low, sampled late in high
	task automatic bit_x(input logic b, output logic r);
		wt(2);
		sda_oe_n_o = b;
		wt(2);
		scl_o = 1'b1;
		wt(3);
		r = sda_i;
		wt(1);
		scl_o = 1'b0;
	endtask
	task automatic start;
		wt(2);
		sda_oe_n_o = 1'b1;
		wt(2);
		scl_o = 1'b1;
		wt(4);
		sda_oe_n_o = 1'b0;
		wt(4);
		scl_o = 1'b0;
	endtask
	task automatic stop;
		wt(2);
		sda_oe_n_o = 1'b0;
		wt(2);
		scl_o = 1'b1;
		wt(4);
		sda_oe_n_o = 1'b1;
		wt(4);
	endtask
	task automatic byte_x(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, ack);
	endtask
	// start, nine dummies released, start, stop
	task automatic recover;
		logic r;
		start();
		repeat (9) bit_x(1'b1, r);
		start();
		stop();
	endtask
endmodule

// ### test/seebr_tb.sv
// bench for the eeprom bus-recovery control block
`timescale 1ns/10ps
module seebr_tb;
	import seebr_pkg::*;
	logic       ref_clk_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       low_vdd_i = 1'b0;
	wire        scl;
	wire        m_oe_n;
	wire        sda;
	logic       sda_o, sda_oe_n_o, busy_o, ready_o, wr_start_o, wr_cancel_o;
	logic [7:0] wr_count_o;
	logic       ack, r;
	logic [7:0] rd_data = 8'h35;
	logic [7:0] rx;
	int         n_errors = 0;
	int         total_checks = 0;
	int         n_start = 0;
	int         n_cancel = 0;
	// pull-up wire
	assign sda = m_oe_n & (sda_oe_n_o | sda_o);
	seebr_master_model M (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));
	seebr_core #(.INIT_CNT(120), .WRITE_CNT(200)) DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.scl_i(scl), .sda_i(sda), .low_vdd_i(low_vdd_i), .rd_data_i(rd_data), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o), .ready_o(ready_o), .wr_start_o(wr_start_o),
		.wr_cancel_o(wr_cancel_o), .wr_count_o(wr_count_o));
	initial
		forever #5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i)
	begin
		n_start += wr_start_o;
		n_cancel += wr_cancel_o;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t %s got %h want %h", $time, m, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_ready;
		int k;
		k = 0;
		while (ready_o !== 1'b1 && k < 300)
		begin
			M.wt(1);
			k++;
		end
		chk(ready_o, 1, "ready");
	endtask
	// write of nb data bytes, pt stray bits before stop
	task automatic wr_seq(input int nb, pt, input logic lv, input int es, ec);
		int s0;
		int c0;
		s0 = n_start;
		c0 = n_cancel;
		low_vdd_i = lv;
		M.start();
		repeat (nb + 3)
		begin
			M.byte_x(8'ha0, ack);
			chk(ack, 0, "ack");
		end
		repeat (pt) M.bit_x(1'b0, r);
		M.stop();
		M.wt(8);
		chk(8'(n_start - s0), 8'(es), "wr");
		chk(8'(n_cancel - c0), 8'(ec), "cancel");
		chk(busy_o, 8'(es), "busy");
		if (es + ec > 0)
			chk(wr_count_o, 8'(nb), "count");
		low_vdd_i = 1'b0;
		if (es > 0)
		begin
			M.start();
			M.byte_x(8'ha0, ack);
			chk(ack, 1, "busy ack");
			M.stop();
			wait_ready();
		end
	endtask
	initial
	begin
		#200us;
		n_errors++;
		end_sim();
	end
	initial
	begin
		repeat (20) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		init_test();
		M.recover();
		wr_seq(1, 0, 1'b0, 1, 0);
		wr_seq(3, 0, 1'b0, 1, 0);
		wr_seq(0, 0, 1'b0, 0, 0);
		wr_seq(1, 4, 1'b0, 0, 0);
		wr_seq(2, 0, 1'b1, 0, 1);
		abort_test();
		read_test();
		stuck_test();
		wr_seq(1, 0, 1'b0, 1, 0);
		end_sim();
	end
	// probe during power-on clear is ignored
	task automatic init_test;
		M.wt(2);
		chk(ready_o, 0, "init");
		M.start();
		M.byte_x(8'ha0, ack);
		chk(ack, 1, "init ack");
		M.stop();
		wait_ready();
	endtask
	// abort a half-shifted command
	task automatic abort_test;
		M.start();
		M.byte_x(8'ha0, ack);
		repeat (3) M.bit_x(1'b0, r);
		wr_seq(1, 0, 1'b0, 1, 0);
	endtask
	// random read: dummy write, repeated start, one byte, master nack
	task automatic read_test;
		int s0;
		s0 = n_start;
		M.start();
		repeat (3)
			M.byte_x(8'ha0, ack);
		M.start();
		M.byte_x(8'ha1, ack);
		chk(ack, 0, "rd ack");
		for (int i = 7; i >= 0; i--)
		begin
			M.bit_x(1'b1, r);
			rx[i] = r;
		end
		chk(rx, rd_data, "rd data");
		M.bit_x(1'b1, ack);
		chk(ack, 1, "nack");
		M.stop();
		M.wt(8);
		chk(sda_oe_n_o, 1, "rd released");
		chk(8'(n_start - s0), 8'h00, "rd no write");
	endtask
	// stuck read of a zero bit survives an idle master
	task automatic stuck_test;
		M.start();
		M.byte_x(8'ha1, ack);
		M.wt(40);
		chk(sda, 0, "held low");
		M.recover();
		chk(sda_oe_n_o, 1, "released");
	endtask
endmodule
